// File: src/ecq_timer.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module ecq_timer #(
   parameter int GATE_CYCLES = ecq_pkg::GATE_CYCLES
) (
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic [ecq_pkg::ADDR_W-1:0] addr,
   input  wire logic [31:0]               wdata,
   input  wire logic                      wr_en,
   input  wire logic                      rd_en,
   output logic      [31:0]               rdata,
   input  wire logic                      tc1_input_a,
   input  wire logic                      tc1_input_b,
   input  wire logic                      tc2_input_a,
   input  wire logic                      tc2_input_b,
   output logic                           divider_out_pin_a,
   output logic                           divider_out_pin_b
);

   // =========================================================
   // Helpers
   function automatic logic reg_hit(input logic [7:0] a, input int ch, input logic [7:0] off);
      reg_hit = (a == 8'(ch * ecq_pkg::CH_STRIDE + int'(off)));
   endfunction

   function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic en);
      sat_inc = (en && v != ecq_pkg::COUNT_MAX) ? 16'(v + 16'h0001) : v;
   endfunction

   // =========================================================
   // Pin mapping and shared gate timer
   logic [ecq_pkg::NUM_CH-1:0] in_a;
   logic [ecq_pkg::NUM_CH-1:0] in_b;
   logic [ecq_pkg::NUM_CH-1:0] out_pin;
   logic [31:0]                ch_rdata [ecq_pkg::NUM_CH];
   logic [31:0]                gate_cnt;
   logic                       gate_end;
   logic [31:0]                rd_mux;

   assign in_a[0] = tc1_input_a;
   assign in_b[0] = tc1_input_b;
   assign in_a[1] = tc2_input_a;
   assign in_b[1] = tc2_input_b;
   assign divider_out_pin_a = out_pin[0];
   assign divider_out_pin_b = out_pin[1];

   // Gate length is fixed in clock cycles, independent of the input rate
   assign gate_end = (gate_cnt == 32'(GATE_CYCLES - 1));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gate_cnt <= 32'h00000000;
      end else if (gate_end) begin
         gate_cnt <= 32'h00000000;
      end else begin
         gate_cnt <= 32'(gate_cnt + 32'h00000001);
      end
   end

   // =========================================================
   // Channels
   for (genvar i = 0; i < ecq_pkg::NUM_CH; i++) begin : g_ch
      logic [ecq_pkg::CTRL_W-1:0] ctrl;
      logic [15:0]                value;
      logic [15:0]                count;
      logic [15:0]                next_count;
      logic [15:0]                capture;
      logic [15:0]                base;
      logic [15:0]                active_n;
      logic [15:0]                pend_n;
      logic [15:0]                next_pend;
      logic [15:0]                cnt;
      logic                       new_flag;
      logic                       out_q;
      logic                       prev_a;
      logic                       prev_b;
      ecq_pkg::ecq_phase_e        phase;
      ecq_pkg::ecq_mode_e         mode;
      logic                       inv;
      logic                       init_hi;
      logic                       wr_ctrl;
      logic                       wr_value;
      logic                       rd_result;
      logic                       edge_act;
      logic                       a_chg;
      logic                       b_chg;
      logic                       q_step;
      logic                       q_up;
      logic                       gen_mode;
      logic                       running;
      logic                       tick;
      logic                       term;
      logic                       load;
      logic                       primed;
      logic                       wr_zero;
      logic                       wr_start;

      assign mode      = ecq_pkg::ecq_mode_e'(ctrl[ecq_pkg::CTRL_MODE_LSB +: ecq_pkg::CTRL_MODE_W]);
      assign inv       = ctrl[ecq_pkg::CTRL_INVERT_BIT];
      assign init_hi   = ctrl[ecq_pkg::CTRL_INIT_BIT];
      assign wr_ctrl   = wr_en && reg_hit(addr, i, ecq_pkg::OFF_CTRL);
      assign wr_value  = wr_en && reg_hit(addr, i, ecq_pkg::OFF_VALUE);
      assign rd_result = rd_en && reg_hit(addr, i, ecq_pkg::OFF_RESULT);

      // Inputs are synchronous; one register gives the previous level
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            prev_a <= 1'b0;
         end else begin
            prev_a <= in_a[i];
         end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            prev_b <= 1'b0;
         end else begin
            prev_b <= in_b[i];
         end
      end

      // Previous levels are not real until one edge after reset; a pin idling
      // high would otherwise look like a rising edge right after release
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            primed <= 1'b0;
         end else begin
            primed <= 1'b1;
         end
      end

      // Falling edge by default; invert selects rising
      assign edge_act = primed
                        & (inv ? (~prev_a & in_a[i]) : (prev_a & ~in_a[i]));

      // Both inputs moving in one cycle is an illegal Gray step: ignored
      assign a_chg  = primed & (in_a[i] ^ prev_a);
      assign b_chg  = primed & (in_b[i] ^ prev_b);
      assign q_step = a_chg ^ b_chg;
      assign q_up   = b_chg ? (in_b[i] == in_a[i]) : (in_a[i] != in_b[i]);

      // -------------------------------------------------------
      // Control and value registers
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            ctrl <= ecq_pkg::CTRL_RESET;
         end else if (wr_ctrl) begin
            ctrl <= wdata[ecq_pkg::CTRL_W-1:0];
         end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            value <= ecq_pkg::VALUE_RESET;
         end else if (wr_value) begin
            value <= wdata[15:0];
         end
      end

      // -------------------------------------------------------
      // Input counter; outside window mode a read clears, but an edge in the same cycle survives
      assign base = rd_result ? 16'h0000 : count;

      always_comb begin
         next_count = 16'h0000;
         case (mode)
            ecq_pkg::ECQ_WINDOW: begin
               next_count = gate_end ? 16'h0000 : sat_inc(count, edge_act);
            end
            ecq_pkg::ECQ_QUAD: begin
               next_count = base;
               if (q_step && q_up && base != ecq_pkg::QUAD_MAX) begin
                  next_count = 16'(base + 16'h0001);
               end else if (q_step && !q_up && base != ecq_pkg::QUAD_MIN) begin
                  next_count = 16'(base - 16'h0001);
               end
            end
            ecq_pkg::ECQ_TOTAL: begin
               next_count = sat_inc(base, edge_act);
            end
            default: begin
               next_count = 16'h0000;
            end
         endcase
      end

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            count <= 16'h0000;
         end else if (wr_ctrl) begin
            count <= 16'h0000;
         end else begin
            count <= next_count;
         end
      end

      // Captured value includes an edge landing on the gate's last cycle
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            capture <= 16'h0000;
         end else if (wr_ctrl) begin
            capture <= 16'h0000;
         end else if (gate_end && mode == ecq_pkg::ECQ_WINDOW) begin
            capture <= sat_inc(count, edge_act);
         end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            new_flag <= 1'b0;
         end else if (wr_ctrl) begin
            new_flag <= 1'b0;
         end else if (gate_end && mode == ecq_pkg::ECQ_WINDOW) begin
            new_flag <= 1'b1;
         end else if (rd_result) begin
            new_flag <= 1'b0;
         end
      end

      // -------------------------------------------------------
      // Output generator shared by divider and frequency modes
      assign gen_mode  = (mode == ecq_pkg::ECQ_DIVIDE) || (mode == ecq_pkg::ECQ_FREQ);
      assign running   = gen_mode && (active_n != 16'h0000);
      assign tick      = (mode == ecq_pkg::ECQ_DIVIDE) ? edge_act : 1'b1;
      assign term      = running && tick && (16'(cnt + 16'h0001) == active_n);
      // Divider reloads at any toggle; frequency only at a full cycle's end
      assign load      = term && ((mode == ecq_pkg::ECQ_DIVIDE)
                                  || (phase == ecq_pkg::ECQ_PH_SECOND));
      assign next_pend = wr_value ? wdata[15:0] : pend_n;

      // Value writes decoded once for all generator registers
      assign wr_zero   = wr_value && gen_mode && (wdata[15:0] == 16'h0000);
      assign wr_start  = wr_value && gen_mode && !wr_zero && (active_n == 16'h0000);

      // Active value; a zero write halts at once, ahead of any pending value
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            active_n <= 16'h0000;
         end else if (wr_ctrl) begin
            active_n <= 16'h0000;
         end else if (wr_zero) begin
            active_n <= 16'h0000;
         end else if (wr_start) begin
            active_n <= wdata[15:0];
         end else if (load) begin
            active_n <= next_pend;
         end
      end

      // Pending value; written any time, taken over at a reload toggle, or at once on a start
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            pend_n <= 16'h0000;
         end else if (wr_ctrl || wr_zero) begin
            pend_n <= 16'h0000;
         end else begin
            pend_n <= next_pend;
         end
      end

      // Tick counter restarts at every toggle and at every start or halt
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            cnt <= 16'h0000;
         end else if (wr_ctrl || wr_zero || wr_start || term) begin
            cnt <= 16'h0000;
         end else if (running && tick) begin
            cnt <= 16'(cnt + 16'h0001);
         end
      end

      // Output level; a control write puts the new initial level on the pin
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            out_q <= 1'b0;
         end else if (wr_ctrl) begin
            out_q <= wdata[ecq_pkg::CTRL_INIT_BIT];
         end else if (wr_zero) begin
            out_q <= init_hi;
         end else if (term) begin
            out_q <= ~out_q;
         end
      end

      // Half-cycle marker; frequency mode reloads only after the second half
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            phase <= ecq_pkg::ECQ_PH_FIRST;
         end else if (wr_ctrl || wr_zero || wr_start) begin
            phase <= ecq_pkg::ECQ_PH_FIRST;
         end else if (term) begin
            phase <= (phase == ecq_pkg::ECQ_PH_FIRST) ? ecq_pkg::ECQ_PH_SECOND
                                                      : ecq_pkg::ECQ_PH_FIRST;
         end
      end

      assign out_pin[i] = out_q;

      // -------------------------------------------------------
      // Read data for this channel, zero unless addressed
      always_comb begin
         ch_rdata[i] = 32'h00000000;
         if (reg_hit(addr, i, ecq_pkg::OFF_CTRL)) begin
            ch_rdata[i] = {27'h0000000, ctrl};
         end else if (reg_hit(addr, i, ecq_pkg::OFF_VALUE)) begin
            ch_rdata[i] = {16'h0000, value};
         end else if (reg_hit(addr, i, ecq_pkg::OFF_RESULT)) begin
            if (mode == ecq_pkg::ECQ_WINDOW) begin
               ch_rdata[i] = {16'h0000, capture};
            end else if (mode == ecq_pkg::ECQ_QUAD) begin
               ch_rdata[i] = {{16{count[15]}}, count};
            end else begin
               ch_rdata[i] = {16'h0000, count};
            end
         end else if (reg_hit(addr, i, ecq_pkg::OFF_STATUS)) begin
            ch_rdata[i][ecq_pkg::ST_NEW_BIT] = new_flag;
            ch_rdata[i][ecq_pkg::ST_OUT_BIT] = out_q;
            ch_rdata[i][ecq_pkg::ST_RUN_BIT] = running;
         end
      end
   end

   // =========================================================
   // Read port; unmapped addresses read zero
   always_comb begin
      rd_mux = 32'h00000000;
      for (int k = 0; k < ecq_pkg::NUM_CH; k++) begin
         rd_mux = rd_mux | ch_rdata[k];
      end
   end

   // Data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= rd_en ? rd_mux : 32'h00000000;
      end
   end

endmodule

`default_nettype wire

// File: src/ecq_pkg.sv
package ecq_pkg;

   // =========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int GATE_TIME_NS  = 838_860_800;
   localparam int GATE_CYCLES   = GATE_TIME_NS / CLK_PERIOD_NS;

   // =========================================================
   // Register map
   localparam int         ADDR_W     = 8;
   localparam int         NUM_CH     = 2;
   localparam int         CH_STRIDE  = 16;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_VALUE  = 8'h04;
   localparam logic [7:0] OFF_RESULT = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;

   // =========================================================
   // Fields and reset values
   localparam int          CTRL_W          = 5;
   localparam int          CTRL_MODE_LSB   = 0;
   localparam int          CTRL_MODE_W     = 3;
   localparam int          CTRL_INVERT_BIT = 3;
   localparam int          CTRL_INIT_BIT   = 4;
   localparam logic [4:0]  CTRL_RESET      = 5'h00;
   localparam logic [15:0] VALUE_RESET     = 16'h0000;
   localparam int          ST_NEW_BIT      = 0;
   localparam int          ST_OUT_BIT      = 1;
   localparam int          ST_RUN_BIT      = 2;

   // =========================================================
   // Count limits
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] QUAD_MAX  = 16'h3FFF;
   localparam logic [15:0] QUAD_MIN  = 16'hC000;

   // =========================================================
   // Modes and states
   typedef enum logic [2:0] {
      ECQ_OFF    = 3'b000,
      ECQ_WINDOW = 3'b001,
      ECQ_QUAD   = 3'b010,
      ECQ_TOTAL  = 3'b011,
      ECQ_DIVIDE = 3'b100,
      ECQ_FREQ   = 3'b101
   } ecq_mode_e;

   typedef enum logic [0:0] {
      ECQ_PH_FIRST  = 1'b0,
      ECQ_PH_SECOND = 1'b1
   } ecq_phase_e;

endpackage

// File: dv/ecq_src.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Pulse source and shaft encoder
module ecq_src (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic       quad,
   input  wire logic       up,
   input  wire logic [7:0] num,
   output logic            busy,
   output var logic        pin_a,
   output var logic        pin_b
);
   logic [7:0] left;
   logic [1:0] gap;
   assign busy = left != 8'h00;
   // One transition per four clocks, the fastest the inputs may move
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         left  <= 8'h00;
         gap   <= 2'h0;
         pin_a <= 1'b1;
         pin_b <= 1'b1;
      end else if (go) begin
         left <= num;
         gap  <= 2'h0;
      end else if (busy) begin
         gap <= gap + 2'h1;
         if (gap == 2'h3) begin
            left <= left - 8'h01;
            if (!quad || (pin_a == pin_b) == up) begin
               pin_a <= !pin_a;
            end else begin
               pin_b <= !pin_b;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/ecq_timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port checker
module ecq_timer_monitor #(
   parameter int GATE_CYCLES = 64
) (
   input wire logic                       ref_clk,
   input wire logic                       rst,
   input wire logic [ecq_pkg::ADDR_W-1:0] addr,
   input wire logic [31:0]                wdata,
   input wire logic                       wr_en,
   input wire logic                       rd_en,
   input wire logic [31:0]                rdata,
   input wire logic                       tc1_input_a,
   input wire logic                       tc1_input_b,
   input wire logic                       tc2_input_a,
   input wire logic                       tc2_input_b,
   input wire logic                       divider_out_pin_a,
   input wire logic                       divider_out_pin_b
);
   logic [2:0]  mode0;
   logic        inv0, init0, init1, out_q, cl_now, cl_prev;
   logic [15:0] len, plen;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode0 <= 3'h0;
         inv0  <= 1'b0;
         init0 <= 1'b0;
         init1 <= 1'b0;
      end else if (wr_en && addr == 8'h00) begin
         mode0 <= wdata[2:0];
         inv0  <= wdata[3];
         init0 <= wdata[4];
      end else if (wr_en && addr == 8'h10) begin
         init1 <= wdata[4];
      end
   end
   // Phase lengths of pin a; a write spoils the phase it falls in
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_q   <= 1'b0;
         len     <= 16'h0000;
         plen    <= 16'h0000;
         cl_now  <= 1'b0;
         cl_prev <= 1'b0;
      end else begin
         out_q <= divider_out_pin_a;
         if (divider_out_pin_a != out_q) begin
            len     <= 16'h0001;
            plen    <= len;
            cl_now  <= !wr_en;
            cl_prev <= cl_now;
         end else begin
            len <= len + 16'h0001;
            if (wr_en) cl_now <= 1'b0;
         end
      end
   end
   sequence s_zero_a;
      wr_en && addr == 8'h04 && wdata[15:0] == 16'h0000;
   endsequence
   sequence s_zero_b;
      wr_en && addr == 8'h14 && wdata[15:0] == 16'h0000;
   endsequence
   sequence s_ctrl_a;
      wr_en && addr == 8'h00;
   endsequence
   AST_ZERO_OFF_A: assert property (s_zero_a |=> divider_out_pin_a == init0)
      else $error("Pin a not off after zero divisor");
   AST_ZERO_OFF_B: assert property (s_zero_b |=> divider_out_pin_b == init1)
      else $error("Pin b not off after zero divisor");
   AST_INIT_LEVEL: assert property (s_ctrl_a |=> (divider_out_pin_a == init0)[*2])
      else $error("Pin a not at initial level");
   AST_HOLD_IDLE: assert property (mode0 < 3'h4 && !$past(wr_en)
      |-> $stable(divider_out_pin_a)) else $error("Pin a moved in input mode");
   AST_DIV_SYNC: assert property (mode0 == 3'h4 && !$past(wr_en)
      && $changed(divider_out_pin_a) |-> ($past(tc1_input_a, 2) ^ inv0)
      && !($past(tc1_input_a, 1) ^ inv0)) else $error("Toggle without sync edge");
   AST_FREQ_DUTY: assert property (mode0 == 3'h5 && cl_now && cl_prev
      && divider_out_pin_a != out_q && divider_out_pin_a == init0 |-> len == plen)
      else $error("Square wave phases unequal");
   AST_QUAD_SAT: assert property (rd_en && addr == 8'h08 && mode0 == 3'h2
      |=> rdata[31:14] == 18'h00000 || rdata[31:14] == 18'h3FFFF)
      else $error("Quadrature result out of range");
   AST_TOTAL_SPAN: assert property (rd_en && addr == 8'h08 && mode0 == 3'h3
      |=> rdata[31:16] == 16'h0000) else $error("Total result out of range");
endmodule
bind ecq_timer ecq_timer_monitor #(.GATE_CYCLES(GATE_CYCLES)) u_mon (
   .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
   .rdata(rdata), .tc1_input_a(tc1_input_a), .tc1_input_b(tc1_input_b),
   .tc2_input_a(tc2_input_a), .tc2_input_b(tc2_input_b),
   .divider_out_pin_a(divider_out_pin_a), .divider_out_pin_b(divider_out_pin_b));
`default_nettype wire

// File: dv/ecq_timer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(x, y) begin comparisons++; if ((x) !== (y)) begin fails++; \
   $display("MISMATCH %0t got %0h want %0h", $time, x, y); end end
// ==========
// Bench top
module ecq_timer_tb_top;
   logic        ref_clk, rst, wr_en, rd_en, pa, pb, a1, b1, a2, b2, quad, up, s, inv, ini;
   logic [7:0]  addr, num;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  go, busy;
   integer      seed;
   int          fails, comparisons, k, t, n, m, e;
   ecq_timer #(.GATE_CYCLES(64)) uut (.ref_clk(ref_clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .tc1_input_a(a1),
      .tc1_input_b(b1), .tc2_input_a(a2), .tc2_input_b(b2), .divider_out_pin_a(pa),
      .divider_out_pin_b(pb));
   ecq_src src0 (.ref_clk(ref_clk), .rst(rst), .go(go[0]), .quad(quad), .up(up), .num(num),
      .busy(busy[0]), .pin_a(a1), .pin_b(b1));
   ecq_src src1 (.ref_clk(ref_clk), .rst(rst), .go(go[1]), .quad(quad), .up(up), .num(num),
      .busy(busy[1]), .pin_a(a2), .pin_b(b2));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   function automatic int rnd(input int r);
      return $unsigned($random(seed)) % r;
   endfunction
   // Active edges among t toggles starting from level st
   function automatic int edges(input logic st, input int t, input logic iv);
      int f;
      f = st ? (t + 1) / 2 : t / 2;
      return iv ? t - f : f;
   endfunction
   task automatic wrap_up();
      $display("Comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      @(posedge ref_clk);
      addr  <= ad;
      wdata <= dt;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] ad);
      @(posedge ref_clk);
      addr  <= ad;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic run(input int ch, input logic q, input logic u, input int tn);
      int i;
      @(posedge ref_clk);
      quad     <= q;
      up       <= u;
      num      <= tn[7:0];
      go[ch]   <= 1'b1;
      @(posedge ref_clk);
      go[ch]   <= 1'b0;
      #1;
      for (i = 0; i < 2000 && busy[ch]; i++) @(posedge ref_clk);
      if (busy[ch]) begin
         fails++;
         wrap_up();
      end
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_new();
      int i;
      for (i = 0; i < 100; i++) begin
         rd(8'h0C);
         if (d[0] === 1'b1) return;
      end
      fails++;
      wrap_up();
   endtask
   // Cycles until pin a next changes
   task automatic phase(output int len);
      logic v;
      v = pa;
      len = 0;
      do begin
         @(posedge ref_clk);
         #1 len++;
      end while (pa === v && len < 200);
      if (len >= 200) begin
         fails++;
         wrap_up();
      end
   endtask
   initial begin
      seed = 32'hacebaebe;
      {rst, wr_en, rd_en, quad, up, go, addr, num, wdata} = {1'b1, 54'h0};
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      for (k = 0; k < 2; k++) begin
         wr(8'h00, 32'h3 | (k << 3));
         t = 1 + rnd(30);
         s = a1;
         run(0, 1'b0, 1'b0, t);
         rd(8'h08);
         `CHK(d, 32'(edges(s, t, k[0])))
         rd(8'h08);
         `CHK(d, 32'h0)
         $display("Total count test %0d done", k);
      end
      for (k = 0; k < 2; k++) begin
         wr(8'(k * 16), 32'h2);
         n = 1 + rnd(40);
         m = rnd(60);
         run(k, 1'b1, 1'b1, n);
         run(k, 1'b1, 1'b0, m);
         rd(8'(k * 16 + 8));
         `CHK(d, 32'(n - m))
         rd(8'(k * 16 + 8));
         `CHK(d, 32'h0)
         $display("Quadrature test %0d done", k);
      end
      wr(8'h00, 32'h1);
      wait_new();
      rd(8'h08);
      t = 1 + rnd(9);
      s = a1;
      run(0, 1'b0, 1'b0, t);
      wait_new();
      rd(8'h08);
      `CHK(d, 32'(edges(s, t, 1'b0)))
      rd(8'h0C);
      `CHK(d[0], 1'b0)
      wait_new();
      rd(8'h08);
      `CHK(d, 32'h0)
      $display("Window test done");
      inv = 1'(rnd(2));
      ini = 1'(rnd(2));
      n = 1 + rnd(3);
      m = 1 + rnd(3);
      t = 1 + rnd(20);
      wr(8'h00, {27'h0, ini, inv, 3'h4});
      `CHK(pa, ini)
      wr(8'h04, n);
      wr(8'h04, m);
      s = a1;
      run(0, 1'b0, 1'b0, t);
      e = edges(s, t, inv);
      k = e < n ? 0 : 1 + (e - n) / m;
      `CHK(pa, ini ^ k[0])
      wr(8'h04, 0);
      `CHK(pa, ini)
      rd(8'h0C);
      `CHK(d[2:1], {1'b0, ini})
      wr(8'h04, m);
      s = a1;
      run(0, 1'b0, 1'b0, t);
      k = edges(s, t, inv) / m;
      `CHK(pa, ini ^ k[0])
      wr(8'h14, 0);
      `CHK(pb, 1'b0)
      $display("Divider test done");
      n = 2 + rnd(6);
      m = 2 + rnd(6);
      wr(8'h00, {27'h0, ini, 4'h5});
      wr(8'h04, n);
      phase(e);
      for (k = 0; k < 3; k++) begin
         phase(e);
         `CHK(e, n)
      end
      wr(8'h04, m);
      repeat (3) phase(e);
      phase(e);
      `CHK(e, m)
      $display("Frequency test done");
      wrap_up();
   end
endmodule
`default_nettype wire
